/* File: src/wdft_pkg.sv */
// Purpose: Shared constants and types for the watchdog with fetch trap.
// Assumes: Core clock is also the high-frequency clock of the device.
// Notes: Register indices are word indices; byte address is four times the index.
package wdft_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FC_HZ = 20_000_000;

  // Avalon-MM slave geometry
  localparam int unsigned AV_ADDR_W = 10;
  localparam int unsigned AV_DATA_W = 32;

  // Register word indices
  localparam logic [7:0] IDX_CONTROL_ONE = 8'h34;
  localparam logic [7:0] IDX_CODE_PORT = 8'h35;
  localparam logic [7:0] IDX_STATUS = 8'h36;

  // Field positions in wd_control_one
  localparam int unsigned POS_OVF_ACTION = 0;
  localparam int unsigned POS_PERIOD = 1;
  localparam int unsigned POS_ENABLE = 3;
  localparam int unsigned POS_TRAP_ACTION = 4;
  localparam int unsigned POS_RAM_TRAP = 5;

  // Reset values
  localparam logic RST_OVF_ACTION = 1'b1;
  localparam logic [1:0] RST_PERIOD = 2'h0;
  localparam logic RST_ENABLE = 1'b1;
  localparam logic RST_TRAP_ACTION = 1'b1;
  localparam logic RST_RAM_TRAP = 1'b1;

  // Control codes
  localparam logic [7:0] CODE_CLEAR = 8'h4e;
  localparam logic [7:0] CODE_DISABLE = 8'hb1;
  localparam logic [7:0] CODE_TRAP_COMMIT = 8'hd2;

  // Divider: longest tap gives a quarter of the longest detection time
  localparam int unsigned DIV_W_DEFAULT = 23;

  // Internal reset length, in high-frequency clock periods
  localparam int unsigned RST_FC_PERIODS = 24;
  localparam int unsigned RST_CYCLES = (RST_FC_PERIODS * (CLK_HZ / 1000)) / (FC_HZ / 1000);

  // Default trap areas
  localparam logic [15:0] SFR_HI_DEFAULT = 16'h003f;
  localparam logic [15:0] RAM_LO_DEFAULT = 16'h0040;
  localparam logic [15:0] RAM_HI_DEFAULT = 16'h023f;

  typedef struct packed {
    logic ram_trap_select;
    logic trap_action_select;
    logic count_enable_bit;
    logic [1:0] detect_period_select;
    logic overflow_action_select;
  } wdft_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } wdft_fetch_t;
endpackage

/* File: src/wdft_divider.sv */
// Purpose: Free-running prescaler with selectable tap for the watchdog.
// Assumes: Tap select changes only while the watchdog is disabled.
// Notes: Tick is one cycle wide; divider is not touched by the clear code.
`timescale 1ns/1ps
module wdft_divider #(
  parameter int unsigned DIV_W = 23
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic i_hold,
  input wire logic [1:0] i_tap_sel,
  output logic o_tick
);
  import wdft_pkg::*;

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] mask;

  // Each select step shortens the period by a factor of four
  assign mask = {DIV_W{1'b1}} >> {i_tap_sel, 1'b0};
  assign o_tick = i_run && !i_hold && ((cnt & mask) == mask);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= '0;
    end else if (!i_run) begin
      cnt <= '0;
    end else if (!i_hold) begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

/* File: src/wdft_pulse_stretch.sv */
// Purpose: Turns a request pulse into an internal reset of fixed length.
// Assumes: Requests during an active pulse are absorbed.
// Notes: Length never exceeds LEN cycles, so a retrigger cannot stretch it.
`timescale 1ns/1ps
module wdft_pulse_stretch #(
  parameter int unsigned LEN = 24
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  output logic o_pulse
);
  import wdft_pkg::*;

  localparam logic [7:0] LAST = 8'(LEN - 1);
  logic [7:0] cnt;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pulse <= 1'b0;
      cnt <= 8'h00;
    end else if (o_pulse) begin
      if (cnt == 8'h00) begin
        o_pulse <= 1'b0;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end else if (i_start) begin
      o_pulse <= 1'b1;
      cnt <= LAST;
    end
  end
endmodule

/* File: src/wdft_top.sv */
// Purpose: Watchdog timer with instruction-fetch address trap, Avalon-MM slave.
// Assumes: Fetch bus and low-power hold are synchronous to i_core_clk.
// Notes: Irq outputs are pending levels, cleared by the CPU accept pulse.
// Operation
// - Counting runs only while enabled; enable is set at reset.
// - Binary counters stay cleared while the watchdog is disabled.
// - Overflow with overflow action zero raises the watchdog interrupt.
// - Watchdog interrupt is non-maskable, independent of interrupt master flag.
// - New watchdog interrupt is raised even while another is in service.
// - Overflow with action one resets internal hardware for at most 24 fc.
// - Code port accepts clear, disable and trap commit codes; others ignored.
// - RAM trap select takes effect only after the commit code.
// - Fetch from special register area always traps.
// - Trap action select chooses interrupt or reset for a trap.
// - With trap action zero, trapped fetch raises non-maskable trap interrupt.
// - New trap interrupt is raised even while another is in service.
// - With trap action one, trapped fetch resets hardware for at most 24 fc.
// - The same register pair holds watchdog and trap controls.
// - Disable code works only when the enable bit is already zero.
// - Overflow action, once zero, cannot return to one until reset.
// - Counting pauses in stop, idle and sleep modes and then resumes.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module wdft_top #(
  parameter int unsigned P_DIV_W = wdft_pkg::DIV_W_DEFAULT,
  parameter logic [15:0] P_SFR_HI = wdft_pkg::SFR_HI_DEFAULT,
  parameter logic [15:0] P_RAM_LO = wdft_pkg::RAM_LO_DEFAULT,
  parameter logic [15:0] P_RAM_HI = wdft_pkg::RAM_HI_DEFAULT
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [wdft_pkg::AV_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [wdft_pkg::AV_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [wdft_pkg::AV_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire wdft_pkg::wdft_fetch_t i_fetch,
  input wire logic i_low_power_hold,
  input wire logic i_wd_irq_ack,
  input wire logic i_trap_irq_ack,
  output logic o_wd_overflow_irq,
  output logic o_fetch_trap_irq,
  output logic o_hw_reset
);
  import wdft_pkg::*;

  wdft_ctrl_t ctrl;
  logic ram_trap_active;
  logic run_q;
  logic [1:0] bin_cnt;
  logic tick;
  logic ovf;
  logic accept;
  logic ctrl_we;
  logic code_we;
  logic clear_cmd;
  logic disable_cmd;
  logic commit_cmd;
  logic in_sfr;
  logic in_ram;
  logic trap;
  logic rst_req;
  logic [7:0] word_idx;
  logic [AV_DATA_W-1:0] next_readdata;

  // Bus decode: one wait state, then the access completes
  assign word_idx = i_avs_address[AV_ADDR_W-1:2];
  assign accept = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign ctrl_we = accept && i_avs_write && (i_avs_address[1:0] == 2'h0)
    && (word_idx == IDX_CONTROL_ONE) && i_avs_byteenable[0];
  assign code_we = accept && i_avs_write && (i_avs_address[1:0] == 2'h0)
    && (word_idx == IDX_CODE_PORT) && i_avs_byteenable[0];
  // Any other code value falls through all three decodes
  assign clear_cmd = code_we && (i_avs_writedata[7:0] == CODE_CLEAR);
  assign disable_cmd = code_we && (i_avs_writedata[7:0] == CODE_DISABLE);
  assign commit_cmd = code_we && (i_avs_writedata[7:0] == CODE_TRAP_COMMIT);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Control registers are write-only; state is visible through status
  always_comb begin
    next_readdata = '0;
    if (i_avs_address[1:0] == 2'h0 && word_idx == IDX_STATUS) begin
      next_readdata[9:0] = {bin_cnt, ram_trap_active, ctrl.ram_trap_select,
        ctrl.trap_action_select, run_q, ctrl.count_enable_bit,
        ctrl.detect_period_select, ctrl.overflow_action_select};
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl.ram_trap_select <= RST_RAM_TRAP;
      ctrl.trap_action_select <= RST_TRAP_ACTION;
      ctrl.count_enable_bit <= RST_ENABLE;
      ctrl.detect_period_select <= RST_PERIOD;
      ctrl.overflow_action_select <= RST_OVF_ACTION;
    end else if (ctrl_we) begin
      ctrl.ram_trap_select <= i_avs_writedata[POS_RAM_TRAP];
      ctrl.trap_action_select <= i_avs_writedata[POS_TRAP_ACTION];
      ctrl.count_enable_bit <= i_avs_writedata[POS_ENABLE];
      ctrl.detect_period_select <= i_avs_writedata[POS_PERIOD +: 2];
      // Sticky once cleared to zero
      ctrl.overflow_action_select <= ctrl.overflow_action_select
        & i_avs_writedata[POS_OVF_ACTION];
    end
  end

  // Staged RAM trap select reaches the decoder only on commit
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ram_trap_active <= RST_RAM_TRAP;
    end else if (commit_cmd) begin
      ram_trap_active <= ctrl.ram_trap_select;
    end
  end

  // Clearing the enable bit alone keeps the watchdog running
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_q <= 1'b1;
    end else if (ctrl_we && i_avs_writedata[POS_ENABLE]) begin
      run_q <= 1'b1;
    end else if (disable_cmd && !ctrl.count_enable_bit) begin
      run_q <= 1'b0;
    end
  end

  wdft_divider #(
    .DIV_W(P_DIV_W)
  ) u_divider (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(run_q),
    .i_hold(i_low_power_hold),
    .i_tap_sel(ctrl.detect_period_select),
    .o_tick(tick)
  );

  assign ovf = tick && (bin_cnt == 2'h3);

  // Clear code wins over a tick in the same cycle for bin_cnt; ovf from that tick still fires
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bin_cnt <= 2'h0;
    end else if (!run_q) begin
      bin_cnt <= 2'h0;
    end else if (clear_cmd) begin
      bin_cnt <= 2'h0;
    end else if (tick) begin
      bin_cnt <= bin_cnt + 2'h1;
    end
  end

  assign in_sfr = i_fetch.addr <= P_SFR_HI;
  assign in_ram = (i_fetch.addr >= P_RAM_LO) && (i_fetch.addr <= P_RAM_HI);
  assign trap = i_fetch.valid && (in_sfr || (in_ram && ram_trap_active));

  // Interrupt master flag never gates these; a new event re-raises even in service
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wd_overflow_irq <= 1'b0;
    end else if (ovf && !ctrl.overflow_action_select) begin
      o_wd_overflow_irq <= 1'b1;
    end else if (i_wd_irq_ack) begin
      o_wd_overflow_irq <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fetch_trap_irq <= 1'b0;
    end else if (trap && !ctrl.trap_action_select) begin
      o_fetch_trap_irq <= 1'b1;
    end else if (i_trap_irq_ack) begin
      o_fetch_trap_irq <= 1'b0;
    end
  end

  // Length counted in core cycles, which are the high-frequency clock
  assign rst_req = (ovf && ctrl.overflow_action_select)
    || (trap && ctrl.trap_action_select);

  wdft_pulse_stretch #(
    .LEN(RST_CYCLES)
  ) u_reset_pulse (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(rst_req),
    .o_pulse(o_hw_reset)
  );

  logic [7:0] rst_len;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_len <= 8'h00;
    end else if (o_hw_reset) begin
      rst_len <= rst_len + 8'h01;
    end else begin
      rst_len <= 8'h00;
    end
  end

  a_disabled_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !run_q |=> bin_cnt == 2'h0)
    else $error("binary counter not cleared while disabled");

  a_ovf_to_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ovf && !ctrl.overflow_action_select |=> o_wd_overflow_irq)
    else $error("overflow did not raise watchdog interrupt");

  a_ovf_to_reset: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ovf && ctrl.overflow_action_select && !o_hw_reset |=> o_hw_reset)
    else $error("overflow did not start internal reset");

  a_reset_length: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    rst_len <= 8'(RST_CYCLES))
    else $error("internal reset too long");

  a_ovf_sel_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !ctrl.overflow_action_select |=> !ctrl.overflow_action_select)
    else $error("overflow action returned to reset");

  a_disable_guard: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    run_q && disable_cmd && ctrl.count_enable_bit |=> run_q)
    else $error("disable code acted with enable bit set");

  a_ram_commit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ram_trap_active != $past(ram_trap_active) |-> $past(commit_cmd))
    else $error("ram trap select changed without commit");

  a_sfr_trap_irq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_fetch.valid && in_sfr && !ctrl.trap_action_select |=> o_fetch_trap_irq)
    else $error("fetch from register area not trapped");

  a_trap_reset: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    trap && ctrl.trap_action_select && !o_hw_reset |=> o_hw_reset[*2])
    else $error("trap did not start internal reset");

  a_clear_code: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    clear_cmd |=> bin_cnt == 2'h0)
    else $error("clear code did not clear counter");

  a_low_power_pause: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_low_power_hold && run_q && !clear_cmd |=> $stable(bin_cnt))
    else $error("counter moved in low power mode");

  a_irq_pending: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_wd_overflow_irq && !i_wd_irq_ack |=> o_wd_overflow_irq)
    else $error("watchdog interrupt lost before accept");
endmodule

/* File: test/wdft_cpu_model.sv */
// Purpose: CPU side model that fetches and accepts the non-maskable requests.
// Assumes: Requests are levels that drop after the accept pulse.
// Notes: Accept comes a set number of cycles after a request, to test slow service.
`timescale 1ns/1ps
module wdft_cpu_model (
  input wire logic i_core_clk,
  input wire logic [3:0] i_ack_delay,
  input wire logic i_wd_irq,
  input wire logic i_trap_irq,
  output logic o_wd_ack,
  output logic o_trap_ack,
  output wdft_pkg::wdft_fetch_t o_fetch
);
  import wdft_pkg::*;
  logic [3:0] wd_cnt = 4'h0;
  logic [3:0] tr_cnt = 4'h0;
  initial o_fetch = '0;
  // Accepted whatever the master flag; a new request is taken while one is served
  always_ff @(posedge i_core_clk) begin
    wd_cnt <= (i_wd_irq && !o_wd_ack) ? wd_cnt + 4'h1 : 4'h0;
    tr_cnt <= (i_trap_irq && !o_trap_ack) ? tr_cnt + 4'h1 : 4'h0;
  end
  assign o_wd_ack = i_wd_irq && (wd_cnt == i_ack_delay);
  assign o_trap_ack = i_trap_irq && (tr_cnt == i_ack_delay);
  task automatic fetch(input logic [15:0] a);
    @(posedge i_core_clk);
    o_fetch <= '{valid: 1'b1, addr: a};
    @(posedge i_core_clk);
    o_fetch <= '0;
  endtask
endmodule

/* File: test/test_wdft_top.sv */
// Purpose: Self-checking bench for the watchdog with fetch trap.
// Assumes: Small divider width keeps detection times short.
// Notes: Flags are looked at on the falling edge, the value the next rising edge sees.
`timescale 1ns/1ps
module test_wdft_top;
  import wdft_pkg::*;
  localparam logic [9:0] A_CTL = 10'h0d0;
  localparam logic [9:0] A_CODE = 10'h0d4;
  localparam logic [9:0] A_STAT = 10'h0d8;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] readdata, q;
  logic waitrequest, wd_ack, trap_ack, wd_irq, trap_irq, hw_reset;
  logic hold = 1'b0;
  logic [3:0] ack_delay = 4'h3;
  logic [7:0] bad [4] = '{8'h00, 8'h4f, 8'hd3, 8'hb0};
  wdft_fetch_t fetch;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wd_rises = 0;
  int hw_rises = 0;
  int n, w, h;
  logic wd_last = 1'b0;
  logic hw_last = 1'b0;

  wdft_top #(.P_DIV_W(7)) dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest), .i_fetch(fetch),
    .i_low_power_hold(hold),
    .i_wd_irq_ack(wd_ack), .i_trap_irq_ack(trap_ack), .o_wd_overflow_irq(wd_irq),
    .o_fetch_trap_irq(trap_irq), .o_hw_reset(hw_reset));
  wdft_cpu_model cpu (.i_core_clk(i_core_clk), .i_ack_delay(ack_delay), .i_wd_irq(wd_irq),
    .i_trap_irq(trap_irq), .o_wd_ack(wd_ack), .o_trap_ack(trap_ack), .o_fetch(fetch));

  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end
  always @(negedge i_core_clk) begin
    if (wd_irq === 1'b1 && !wd_last) wd_rises++;
    if (hw_reset === 1'b1 && !hw_last) hw_rises++;
    wd_last = (wd_irq === 1'b1);
    hw_last = (hw_reset === 1'b1);
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Read before this edge's updates land, so these are the values standing at it
    do @(posedge i_core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic st(input string name, input logic [31:0] exp, input logic [31:0] mask);
    xfer(1'b0, A_STAT, 32'h0);
    chk(name, exp, q & mask);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? hw_reset : (s == 1 ? wd_irq : trap_irq);
  endfunction
  task automatic wait_hi(input string name, input int s, input int lim);
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (pick(s) !== 1'b1 && n < lim);
    chk(name, 32'h1, {31'h0, pick(s)});
  endtask
  task automatic reset_len();
    wait_hi("hw reset", 0, 60);
    n = 0;
    while (hw_reset === 1'b1) begin
      n++;
      @(negedge i_core_clk);
    end
    chk("hw reset length", RST_CYCLES, n);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    st("status at reset", 32'hf9, 32'h3ff);
    xfer(1'b0, A_CTL, 32'h0);
    chk("control read", 32'h0, q);
    xfer(1'b0, 10'h3fc, 32'h0);
    chk("unmapped read", 32'h0, q);
    xfer(1'b1, A_CODE, {24'h0, CODE_CLEAR});
    cpu.fetch(16'h0010);
    reset_len();
    cpu.fetch(16'h0100);
    reset_len();
    xfer(1'b1, A_CTL, 32'h09);
    st("staged ram select", 32'h99, 32'hff);
    // Lane zero off: the whole write must be dropped
    avs_byteenable <= 4'he;
    xfer(1'b1, A_CTL, 32'h29);
    avs_byteenable <= 4'hf;
    st("write without lane zero", 32'h99, 32'hff);
    cpu.fetch(16'h0100);
    wait_hi("ram trap irq", 2, 3);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, A_CODE, {24'h0, bad[i]});
    end
    st("after invalid codes", 32'h99, 32'hff);
    xfer(1'b1, A_CODE, {24'h0, CODE_TRAP_COMMIT});
    st("committed ram select", 32'h19, 32'hff);
    cpu.fetch(16'h0100);
    repeat (4) @(negedge i_core_clk);
    chk("ram fetch untrapped", 32'h0, {31'h0, trap_irq});
    cpu.fetch(16'h0020);
    wait_hi("sfr trap irq", 2, 3);
    xfer(1'b1, A_CTL, 32'h0d);
    h = hw_rises;
    for (int i = 0; i < 14; i++) begin
      xfer(1'b1, A_CODE, {24'h0, CODE_CLEAR});
    end
    chk("no reset while cleared", h, hw_rises);
    reset_len();
    xfer(1'b1, A_CTL, 32'h0c);
    ack_delay <= 4'ha;
    @(negedge i_core_clk);
    h = hw_rises;
    w = wd_rises;
    wait_hi("wd irq", 1, 60);
    cpu.fetch(16'h0010);
    wait_hi("trap irq in service", 2, 3);
    repeat (80) @(posedge i_core_clk);
    chk("wd irq repeats", 32'h1, {31'h0, wd_rises >= w + 2});
    chk("no reset on irq action", h, hw_rises);
    xfer(1'b1, A_CTL, 32'h0d);
    st("overflow action locked", 32'h1c, 32'hff);
    xfer(1'b1, A_CODE, {24'h0, CODE_DISABLE});
    st("disable while enabled", 32'h1c, 32'hff);
    xfer(1'b1, A_CODE, {24'h0, CODE_CLEAR});
    xfer(1'b1, A_CTL, 32'h02);
    xfer(1'b1, A_CODE, {24'h0, CODE_DISABLE});
    st("disabled", 32'h002, 32'h3ff);
    w = wd_rises;
    repeat (100) @(posedge i_core_clk);
    st("still disabled", 32'h002, 32'h3ff);
    chk("no irq while disabled", w, wd_rises);
    xfer(1'b1, A_CTL, 32'h0c);
    hold <= 1'b1;
    w = wd_rises;
    repeat (80) @(posedge i_core_clk);
    chk("paused in low power", w, wd_rises);
    hold <= 1'b0;
    wait_hi("resumed wd irq", 1, 60);
    // Shortest period: overflow every 8 cycles, so three rises fit in 60
    xfer(1'b1, A_CTL, 32'h0e);
    st("fast period", 32'h1e, 32'hff);
    w = wd_rises;
    repeat (60) @(posedge i_core_clk);
    chk("wd irq fast period", 32'h1, {31'h0, wd_rises >= w + 3});
    // Second reset in mid-run must bring back the reset action
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    st("status after reset", 32'hf9, 32'h3ff);
    chk("irq cleared by reset", 32'h0, {31'h0, wd_irq});
    stop_test();
  end
endmodule
